// ==== hdl/strap_led_button_reset_io.sv ====
/*
 * Strap capture, push-button, LED, PHY reset stretch and PHY clock gate,
 * with an APB register slave.
 * Assumes pads resolved outside: pad_in is the pin level and pad_driven
 * says an external driver is present; pins are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

module strap_led_button_reset_io #(
    parameter int EXT_PHY_RESET_N_CYC = strap_io_pkg::EXT_PHY_RESET_N_STRETCH_CYC,
    parameter int FLASH_CYC = strap_io_pkg::FLASH_HALF_CYC,
    parameter int BLINK_CYC = strap_io_pkg::BLINK_HALF_CYC,
    parameter int DEB_CYC = strap_io_pkg::DEBOUNCE_CYC,
    parameter int RESTORE_MIN = strap_io_pkg::RESTORE_MIN_CYC,
    parameter int RESTORE_MAX = strap_io_pkg::RESTORE_MAX_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] pad_in,
    input wire logic [11:0] pad_driven,
    output logic [11:0] pad_out,
    output logic [11:0] pad_oe,
    input wire logic refclk_25m,
    output logic ext_phy_refclk,
    output logic ext_phy_reset_n,
    output logic mac_mode,
    output logic pair_req,
    output logic restore_req
);

    localparam int W = strap_io_pkg::CNT_W;

    function automatic logic led_mux(input logic link, input logic act, input logic fl);
        return link & (~act | fl);
    endfunction

    function automatic logic reg_hit(input logic [11:0] a);
        return a == strap_io_pkg::OFS_CTRL || a == strap_io_pkg::OFS_STRAP ||
               a == strap_io_pkg::OFS_EVENT || a == strap_io_pkg::OFS_STATE;
    endfunction

    // =====================================================================
    // pin synchronisers
    logic [11:0] pin_meta_q, pin_sync_q, drv_meta_q, drv_sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= strap_io_pkg::PULL_DEFAULT;
            pin_sync_q <= strap_io_pkg::PULL_DEFAULT;
            drv_meta_q <= 12'h000;
            drv_sync_q <= 12'h000;
        end else begin
            pin_meta_q <= pad_in;
            pin_sync_q <= pin_meta_q;
            drv_meta_q <= pad_driven;
            drv_sync_q <= drv_meta_q;
        end
    end

    // =====================================================================
    // strap capture: the synchronisers need two edges after release
    // before they carry the pins, so the sample is taken on the third
    strap_io_pkg::strap_state_t st_q;
    logic [11:0] strap_q;
    logic run;

    assign run = st_q == strap_io_pkg::ST_RUN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= strap_io_pkg::ST_SYNC0;
        end else begin
            case (st_q)
                strap_io_pkg::ST_SYNC0: st_q <= strap_io_pkg::ST_SYNC1;
                strap_io_pkg::ST_SYNC1: st_q <= strap_io_pkg::ST_SAMPLE;
                strap_io_pkg::ST_SAMPLE: st_q <= strap_io_pkg::ST_RUN;
                default: st_q <= strap_io_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_q <= strap_io_pkg::PULL_DEFAULT;
        end else if (st_q == strap_io_pkg::ST_SAMPLE) begin
            strap_q <= (drv_sync_q & pin_sync_q) |
                       (~drv_sync_q & strap_io_pkg::PULL_DEFAULT);
        end
    end

    logic unsupported;
    assign mac_mode = strap_q[strap_io_pkg::PIN_HOSTROLE];
    assign unsupported = ~(strap_q[strap_io_pkg::PIN_BOOTSRC] &
                           strap_q[strap_io_pkg::PIN_MEMCFG]);

    // gated by the captured strap and run, which both change only at capture, so at most one truncated pulse there
    assign ext_phy_refclk = refclk_25m & mac_mode & run;

    // =====================================================================
    // PHY reset stretch
    logic [W-1:0] rst_cnt_q;
    logic ext_phy_reset_n_n_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_q <= '0;
            ext_phy_reset_n_n_q <= 1'b0;
        end else if (!ext_phy_reset_n_n_q) begin
            if (rst_cnt_q == W'(EXT_PHY_RESET_N_CYC - 1)) begin
                ext_phy_reset_n_n_q <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end
    end
    assign ext_phy_reset_n = ext_phy_reset_n_n_q;

    // =====================================================================
    // button debounce; both buttons idle high through their pull-ups
    logic [1:0] btn_raw, btn_q, btn_prev_q;
    logic [W-1:0] deb_cnt_q [2];

    assign btn_raw = {pin_sync_q[strap_io_pkg::PIN_AUTONEG], pin_sync_q[strap_io_pkg::PIN_IFACE1]};

    // one process for both buttons keeps each vector on a single driver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deb_cnt_q <= '{default: '0};
            btn_q <= 2'h3;
            btn_prev_q <= 2'h3;
        end else begin
            btn_prev_q <= btn_q;
            for (int i = 0; i < 2; i++) begin
                if (!run || btn_raw[i] == btn_q[i]) begin
                    deb_cnt_q[i] <= '0;
                end else if (deb_cnt_q[i] == W'(DEB_CYC - 1)) begin
                    deb_cnt_q[i] <= '0;
                    btn_q[i] <= btn_raw[i];
                end else begin
                    deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // =====================================================================
    // pairing press and factory-restore window
    logic [W-1:0] low_cnt_q;
    logic pair_q, restore_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_q <= 1'b0;
        end else begin
            pair_q <= btn_prev_q[0] & ~btn_q[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= '0;
            restore_q <= 1'b0;
        end else begin
            restore_q <= 1'b0;
            if (!btn_q[1]) begin
                if (low_cnt_q != W'(RESTORE_MAX)) begin
                    low_cnt_q <= low_cnt_q + 1'b1;
                end
            end else begin
                low_cnt_q <= '0;
                if (!btn_prev_q[1]) begin
                    // saturation at the upper bound rejects long holds
                    restore_q <= low_cnt_q > W'(RESTORE_MIN) &&
                                 low_cnt_q < W'(RESTORE_MAX);
                end
            end
        end
    end
    assign pair_req = pair_q;
    assign restore_req = restore_q;

    // =====================================================================
    // flash and blink timebases
    logic [W-1:0] flash_cnt_q, blink_cnt_q;
    logic flash_q, blink_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end else if (flash_cnt_q == W'(FLASH_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_q <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == W'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    // =====================================================================
    // registers
    logic [strap_io_pkg::CTRL_W-1:0] ctrl_q;
    logic [1:0] evt_q;
    logic [31:0] rdata_q;
    logic wr_en, hit;

    assign hit = reg_hit(paddr);
    assign wr_en = psel & penable & pwrite & hit;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = rdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= strap_io_pkg::CTRL_RESET;
        end else if (wr_en && paddr == strap_io_pkg::OFS_CTRL) begin
            ctrl_q <= pwdata[strap_io_pkg::CTRL_W-1:0];
        end
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= strap_io_pkg::EVT_RESET;
        end else begin
            evt_q <= (evt_q & ~((wr_en && paddr == strap_io_pkg::OFS_EVENT) ? pwdata[1:0] : 2'h0))
                     | {restore_q, pair_q};
        end
    end

    // read data is latched in the setup cycle and stands through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            rdata_q <= 32'h0000_0000;
            case (paddr)
                strap_io_pkg::OFS_CTRL: rdata_q[strap_io_pkg::CTRL_W-1:0] <= ctrl_q;
                strap_io_pkg::OFS_STRAP: begin
                    rdata_q[11:0] <= strap_q;
                    rdata_q[strap_io_pkg::STRAP_MAC] <= mac_mode;
                    rdata_q[strap_io_pkg::STRAP_UNSUP] <= unsupported;
                    rdata_q[strap_io_pkg::STRAP_DONE] <= run;
                end
                strap_io_pkg::OFS_EVENT: rdata_q[1:0] <= evt_q;
                strap_io_pkg::OFS_STATE: rdata_q[2:0] <= {ext_phy_reset_n_n_q, btn_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // =====================================================================
    // LED drive; pads stay released until the straps are taken
    logic plc_link_led_q, eth_link_led_q, power_led_q;
    logic pwr_led_d;

    always_comb begin
        if (ctrl_q[strap_io_pkg::CTRL_FW_CORRUPT]) begin
            pwr_led_d = blink_q;
        end else if (ctrl_q[strap_io_pkg::CTRL_FW_LOAD]) begin
            pwr_led_d = flash_q;
        end else begin
            pwr_led_d = ctrl_q[strap_io_pkg::CTRL_PWR_READY];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            plc_link_led_q <= 1'b0;
            eth_link_led_q <= 1'b0;
            power_led_q <= 1'b0;
        end else begin
            plc_link_led_q <= run & led_mux(ctrl_q[strap_io_pkg::CTRL_PLC_LINK],
                ctrl_q[strap_io_pkg::CTRL_PLC_ACT], flash_q);
            eth_link_led_q <= run & led_mux(ctrl_q[strap_io_pkg::CTRL_ETH_LINK],
                ctrl_q[strap_io_pkg::CTRL_ETH_ACT], flash_q);
            power_led_q <= run & pwr_led_d;
        end
    end

    always_comb begin
        pad_out = 12'h000;
        pad_oe = 12'h000;
        pad_out[strap_io_pkg::PIN_HOSTROLE] = plc_link_led_q;
        pad_out[strap_io_pkg::PIN_ISOLATE] = eth_link_led_q;
        pad_out[strap_io_pkg::PIN_SPEED1] = power_led_q;
        pad_oe[strap_io_pkg::PIN_HOSTROLE] = run;
        pad_oe[strap_io_pkg::PIN_ISOLATE] = run;
        pad_oe[strap_io_pkg::PIN_SPEED1] = run;
    end

    // =====================================================================
    // checks
    sequence s_press;
        btn_prev_q[0] && !btn_q[0];
    endsequence

    sequence s_release_restore;
        btn_q[1] && !btn_prev_q[1];
    endsequence

    a_strap_held: assert property (@(posedge pclk) disable iff (!presetn)
        run && $past(run) |-> $stable(strap_q))
        else $error("strap value changed after capture");

    a_pads_released: assert property (@(posedge pclk) disable iff (!presetn)
        !run |-> pad_oe == 12'h000)
        else $error("pad driven before strap capture");

    a_pair_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        s_press |=> pair_req ##1 !pair_req)
        else $error("pairing press not reported as one pulse");

    a_restore_window: assert property (@(posedge pclk) disable iff (!presetn)
        s_release_restore |=> restore_req == ($past(low_cnt_q) > W'(RESTORE_MIN) &&
                                              $past(low_cnt_q) < W'(RESTORE_MAX)))
        else $error("restore decision outside the hold window");

    a_plc_led_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[strap_io_pkg::CTRL_PLC_LINK] |=> !plc_link_led_q)
        else $error("powerline led lit without link");

    a_eth_led_on: assert property (@(posedge pclk) disable iff (!presetn)
        run && ctrl_q[strap_io_pkg::CTRL_ETH_LINK] && !ctrl_q[strap_io_pkg::CTRL_ETH_ACT]
        |=> eth_link_led_q)
        else $error("ethernet led dark with idle link");

    a_power_ready: assert property (@(posedge pclk) disable iff (!presetn)
        run && ctrl_q[6:4] == 3'h1 |=> power_led_q)
        else $error("power led dark while ready");

    a_power_blink: assert property (@(posedge pclk) disable iff (!presetn)
        run && ctrl_q[strap_io_pkg::CTRL_FW_CORRUPT] |=> power_led_q == $past(blink_q))
        else $error("power led not blinking on corrupt firmware");

    a_ext_phy_reset_n_stretch: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ext_phy_reset_n_n_q) |-> $past(rst_cnt_q) == W'(EXT_PHY_RESET_N_CYC - 1))
        else $error("phy reset released early");

    a_refclk_phy_mode: assert property (@(posedge pclk) disable iff (!presetn)
        !mac_mode |-> !ext_phy_refclk)
        else $error("reference clock driven in phy mode");

    a_boot_unsup: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == strap_io_pkg::OFS_STRAP |=>
        prdata[strap_io_pkg::STRAP_UNSUP] ==
        !($past(strap_q[strap_io_pkg::PIN_BOOTSRC]) && $past(strap_q[strap_io_pkg::PIN_MEMCFG])))
        else $error("boot combination flag wrong");

endmodule // strap_led_button_reset_io

`default_nettype wire

// ==== hdl/strap_io_pkg.sv ====
/*
 * Constants for the strap, push-button, LED and PHY utility pin block.
 * Assumes a 20 MHz pclk and an APB master with 32-bit data.
 */
// Summary of operation
// - During reset the general-purpose pins are sampled as straps; afterwards they are buttons and LEDs (the code samples on the third pclk edge after release).
// - A strap pin that nobody drives is taken at its internal pull level.
// - After reset a press on the pairing button requests joining or leaving the logical network.
// - Factory restore fires only for a low on its input longer than 0.5 s and shorter than 3.0 s.
// - The powerline LED is on with link, flashes with activity and is off without link.
// - The Ethernet LED is on with link, flashes with activity and is off without link.
// - The power LED is on when power is ready, off when not, and flashes while firmware loads.
// - With corrupt or blank firmware the power LED blinks at one full cycle per second.
// - The active-low PHY reset output follows the module reset and is stretched after release.
// - While the module reset is low all internal logic is held in reset.
// - The captured host-role strap selects PHY mode at 0 and MAC mode at 1.
// - Only boot-source and memory-config-source both high is supported.

`default_nettype none

package strap_io_pkg;

    // =====================================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int RESET_HOLD_US = 100_000;
    localparam int EXT_PHY_RESET_N_STRETCH_US = 10_000;
    localparam int FLASH_HALF_US = 100_000;
    localparam int BLINK_HALF_US = 500_000;
    localparam int DEBOUNCE_US = 10_000;
    localparam int RESTORE_MIN_US = 500_000;
    localparam int RESTORE_MAX_US = 3_000_000;
    localparam int EXT_PHY_RESET_N_STRETCH_CYC = EXT_PHY_RESET_N_STRETCH_US * CYC_PER_US;
    localparam int FLASH_HALF_CYC = FLASH_HALF_US * CYC_PER_US;
    localparam int BLINK_HALF_CYC = BLINK_HALF_US * CYC_PER_US;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CYC_PER_US;
    localparam int RESTORE_MIN_CYC = RESTORE_MIN_US * CYC_PER_US;
    localparam int RESTORE_MAX_CYC = RESTORE_MAX_US * CYC_PER_US;
    localparam int CNT_W = 26;

    // =====================================================================
    // pin indices and pull defaults
    localparam int NPIN = 12;
    localparam int PIN_IFACE0 = 0;
    localparam int PIN_IFACE1 = 1;
    localparam int PIN_AUTONEG = 2;
    localparam int PIN_ISOLATE = 3;
    localparam int PIN_SPEED0 = 4;
    localparam int PIN_ADDR3 = 5;
    localparam int PIN_MEMCFG = 6;
    localparam int PIN_ADDR4 = 7;
    localparam int PIN_HOSTROLE = 8;
    localparam int PIN_BOOTSRC = 10;
    localparam int PIN_SPEED1 = 11;
    localparam logic [11:0] PULL_DEFAULT = 12'h577;

    // =====================================================================
    // register map
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STRAP = 12'h004;
    localparam logic [11:0] OFS_EVENT = 12'h008;
    localparam logic [11:0] OFS_STATE = 12'h00C;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam int CTRL_PLC_LINK = 0;
    localparam int CTRL_PLC_ACT = 1;
    localparam int CTRL_ETH_LINK = 2;
    localparam int CTRL_ETH_ACT = 3;
    localparam int CTRL_PWR_READY = 4;
    localparam int CTRL_FW_LOAD = 5;
    localparam int CTRL_FW_CORRUPT = 6;
    localparam int STRAP_MAC = 16;
    localparam int STRAP_UNSUP = 17;
    localparam int STRAP_DONE = 18;
    localparam int EVT_PAIR = 0;
    localparam int EVT_RESTORE = 1;
    localparam logic [1:0] EVT_RESET = 2'h0;

    typedef enum logic [1:0] {ST_SYNC0, ST_SYNC1, ST_SAMPLE, ST_RUN} strap_state_t;

endpackage

`default_nettype wire

// ==== tb/button_led_far_side.sv ====
/*
 * Far-side model: strap resistors, two push-buttons and the LED pins.
 * Assumes the device takes the LED pins (pad_oe bit 8) once straps are in.
 */
`timescale 1ns/1ns
`default_nettype none

module button_led_far_side (
    input wire logic [11:0] strap_drv,
    input wire logic [11:0] strap_val,
    input wire logic pair_press,
    input wire logic restore_press,
    input wire logic [11:0] pad_out,
    input wire logic [11:0] pad_oe,
    output logic [11:0] pad_in,
    output logic [11:0] pad_driven
);
    // =====================================================================
    // pin resolution
    logic run;
    logic [11:0] ext_val;
    // straps let go once the device drives its LEDs; buttons then own pins 1 and 2
    assign run = pad_oe[8];
    assign pad_driven = run ? 12'h006 : strap_drv;
    assign ext_val = run ? {9'h000, ~restore_press, ~pair_press, 1'b0} : strap_val;
    // a floating pin rests at its pull level, never at a stale driven value
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & pad_driven & ext_val)
        | (~pad_oe & ~pad_driven & strap_io_pkg::PULL_DEFAULT);
endmodule // button_led_far_side

`default_nettype wire

// ==== tb/tb.sv ====
/*
 * Self-checking bench for the strap, button, LED and PHY utility block.
 * Assumes short parameter values so the long counts fit a brief run.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    // =====================================================================
    // setup
    localparam int PHY_N = 8;
    localparam int BL_N = 10;
    typedef struct packed {
        logic [11:0] drv;
        logic [11:0] val;
        logic [31:0] strap;
        logic [6:0] ctrl;
        logic [5:0] led;
    } row_t;
    // led classes, two bits each for plc, eth, power: 0 off, 1 on, 2 flashing
    row_t rows [6] = '{
        '{12'h000, 12'h000, 32'h0005_0577, 7'h01, 6'h10},
        '{12'hFFF, 12'h000, 32'h0006_0000, 7'h03, 6'h20},
        '{12'h500, 12'h400, 32'h0004_0477, 7'h04, 6'h04},
        '{12'h0C8, 12'h088, 32'h0007_05BF, 7'h18, 6'h01},
        '{12'h000, 12'h000, 32'h0005_0577, 7'h3C, 6'h0A},
        '{12'h000, 12'h000, 32'h0005_0577, 7'h52, 6'h02}};
    int lows [3] = '{8, 40, 90};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, refclk_25m;
    logic ext_phy_refclk, ext_phy_reset_n, mac_mode, pair_req, restore_req;
    logic pair_press, restore_press, er, lv;
    logic [11:0] paddr, pad_in, pad_driven, pad_out, pad_oe, strap_drv, strap_val, on, off;
    logic [31:0] pwdata, prdata, rd;
    int err_total, samples_checked, cyc, rc, pair_cnt, rest_cnt, n, p0;

    strap_led_button_reset_io #(.EXT_PHY_RESET_N_CYC(PHY_N), .FLASH_CYC(4), .BLINK_CYC(BL_N),
        .DEB_CYC(3), .RESTORE_MIN(20), .RESTORE_MAX(60)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_driven(pad_driven), .pad_out(pad_out),
        .pad_oe(pad_oe), .refclk_25m(refclk_25m), .ext_phy_refclk(ext_phy_refclk),
        .ext_phy_reset_n(ext_phy_reset_n), .mac_mode(mac_mode), .pair_req(pair_req),
        .restore_req(restore_req));

    button_led_far_side far_u (.strap_drv(strap_drv), .strap_val(strap_val),
        .pair_press(pair_press), .restore_press(restore_press), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_in(pad_in), .pad_driven(pad_driven));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        refclk_25m = 1'b0;
        forever #20 refclk_25m = ~refclk_25m;
    end
    always @(posedge ext_phy_refclk) rc++;
    always @(posedge pclk) begin
        if (pair_req === 1'b1) pair_cnt++;
        if (restore_req === 1'b1) rest_cnt++;
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            results();
        end
    end

    // =====================================================================
    // tasks
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // the wait ends once pready is high, or else at the bench timeout
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task do_reset(input logic [11:0] d, input logic [11:0] v);
        strap_drv <= d;
        strap_val <= v;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("oe_in_reset", {20'h0, pad_oe}, 32'h0);
        chk("ext_phy_reset_n_low", {31'h0, ext_phy_reset_n}, 32'h0);
        presetn <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (ext_phy_reset_n !== 1'b1 && n < 100);
        // register rises at edge PHY_N, seen one edge later
        chk("ext_phy_reset_n_stretch", 32'(n), 32'(PHY_N + 1));
    endtask

    task results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, pair_press, restore_press} = 6'h00;
        {paddr, strap_drv, strap_val, pwdata} = '0;
        {err_total, samples_checked, cyc, rc, pair_cnt, rest_cnt} = '0;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            do_reset(rows[i].drv, rows[i].val);
            apb(1'b0, strap_io_pkg::OFS_STRAP, 32'h0);
            chk("strap_word", rd, rows[i].strap);
            chk("mac_mode", {31'h0, mac_mode}, {31'h0, rows[i].strap[16]});
            chk("pad_oe", {20'h0, pad_oe}, 32'h908);
            rc = 0;
            repeat (20) @(posedge pclk);
            chk("refclk", {31'h0, rc != 0}, {31'h0, rows[i].strap[16]});
            apb(1'b1, strap_io_pkg::OFS_CTRL, {25'h0, rows[i].ctrl});
            repeat (4) @(posedge pclk);
            on = '0;
            off = '0;
            repeat (30) begin
                @(posedge pclk);
                on |= pad_out;
                off |= ~pad_out;
            end
            chk("leds", {26'h0, on[8] & off[8], on[8] & ~off[8], on[3] & off[3],
                on[3] & ~off[3], on[11] & off[11], on[11] & ~off[11]},
                {26'h0, rows[i].led});
            $display("row %0d done", i);
        end
        // blink half period measured between two observed toggles
        for (int h = 0; h < 2; h++) begin
            lv = pad_out[11];
            n = 0;
            while (pad_out[11] === lv && n < 50) begin
                @(posedge pclk);
                n++;
            end
        end
        chk("blink_half", 32'(n), 32'(BL_N));
        $display("blink test done");
        // unmapped write must not land anywhere; strap word is read-only
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_rd", rd, 32'h0);
        apb(1'b1, strap_io_pkg::OFS_STRAP, 32'h0);
        apb(1'b0, strap_io_pkg::OFS_STRAP, 32'h0);
        chk("strap_ro", rd, 32'h0005_0577);
        apb(1'b0, strap_io_pkg::OFS_CTRL, 32'h0);
        chk("ctrl_kept", rd, 32'h52);
        apb(1'b0, strap_io_pkg::OFS_STATE, 32'h0);
        chk("state", rd, 32'h7);
        $display("register test done");
        // a one-cycle glitch is filtered, a held press is one request
        p0 = pair_cnt;
        pair_press <= 1'b1;
        @(posedge pclk);
        pair_press <= 1'b0;
        repeat (15) @(posedge pclk);
        chk("pair_glitch", 32'(pair_cnt - p0), 32'h0);
        pair_press <= 1'b1;
        repeat (10) @(posedge pclk);
        pair_press <= 1'b0;
        repeat (15) @(posedge pclk);
        chk("pair_pulse", 32'(pair_cnt - p0), 32'h1);
        apb(1'b0, strap_io_pkg::OFS_EVENT, 32'h0);
        chk("pair_event", rd, 32'h1);
        apb(1'b1, strap_io_pkg::OFS_EVENT, 32'h1);
        apb(1'b0, strap_io_pkg::OFS_EVENT, 32'h0);
        chk("event_clear", rd, 32'h0);
        chk("pready", {31'h0, pready}, 32'h1);
        $display("pair test done");
        // too short, inside the window, too long
        for (int k = 0; k < 3; k++) begin
            p0 = rest_cnt;
            restore_press <= 1'b1;
            repeat (lows[k]) @(posedge pclk);
            restore_press <= 1'b0;
            repeat (20) @(posedge pclk);
            chk("restore", 32'(rest_cnt - p0), {31'h0, k == 1});
        end
        apb(1'b0, strap_io_pkg::OFS_EVENT, 32'h0);
        chk("restore_event", rd, 32'h2);
        $display("restore test done");
        results();
    end
endmodule // tb

`default_nettype wire
